// [core/bemf_cond.sv]
/*
 * back-emf comparator output conditioning: per phase sync, blanking
 * after a commutation start, demag filter and output filter, then a
 * capture source mux for the timer.
 * assumes raw comparator levels are asynchronous, the blanking start
 * pulse comes from logic on i_mclk, and a plain single-cycle reg port.
 */
// The plain strobed port was decided locally.
`timescale 1ns/10ps
module bemf_cond #(
    parameter int unsigned N_PH = 3
) (
    input  wire logic            i_mclk,
    input  wire logic            i_rst,
    input  wire logic [7:0]      i_addr,
    input  wire logic [31:0]     i_wdata,
    input  wire logic            i_wr,
    input  wire logic            i_rd,
    output logic      [31:0]     o_rdata,
    input  wire logic [N_PH-1:0] i_comp_raw,
    input  wire logic            i_blank_start,
    output logic      [N_PH-1:0] o_phase_crossing_status,
    output logic      [N_PH-1:0] o_comp_on,
    output logic                 o_capture_in
);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    bemf_cond_pkg::trim_s trim_q;
    bemf_cond_pkg::ctrl_s ctrl_q;
    logic [31:0]          rdata_q;
    logic [31:0]          rdata_d;
    logic [N_PH-1:0]      sts_q;
    logic                 cap_q;

    wire hit_trim = i_addr == bemf_cond_pkg::TRIM_OFS;
    wire hit_ctrl = i_addr == bemf_cond_pkg::CTRL_OFS;

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            trim_q <= bemf_cond_pkg::TRIM_RST[9:0];
            ctrl_q <= bemf_cond_pkg::CTRL_RST[5:0];
        end
        else if (i_wr && hit_trim)
        begin
            trim_q <= i_wdata[9:0];
        end
        else if (i_wr && hit_ctrl)
        begin
            ctrl_q <= {i_wdata[bemf_cond_pkg::CTRL_ON_LSB +: 3],
                       i_wdata[bemf_cond_pkg::CTRL_SWTRIG_BIT],
                       i_wdata[bemf_cond_pkg::CTRL_BYP_BIT],
                       i_wdata[bemf_cond_pkg::CTRL_DEMAG_BIT]};
        end
    end

    wire [31:0] trim_word = {22'h0, trim_q};
    wire [31:0] ctrl_word = {13'h0, sts_q, 5'h0, ctrl_q.comp_on, 2'h0,
                             ctrl_q.capture_soft_trigger, ctrl_q.output_filter_bypass,
                             ctrl_q.demag_filter_disable, 3'h0};

    always_comb
    begin
        rdata_d = 32'h0;
        if (i_rd && hit_trim)
            rdata_d = trim_word;
        else if (i_rd && hit_ctrl)
            rdata_d = ctrl_word;
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            rdata_q <= 32'h0;
        else
            rdata_q <= rdata_d;
    end

    // ------------------------------------------------------------
    // time selection
    // ------------------------------------------------------------
    logic [bemf_cond_pkg::CNT_W-1:0] filt_cyc;
    logic [bemf_cond_pkg::CNT_W-1:0] blank_cyc;

    always_comb
    begin
        case (trim_q.output_filter_time_sel)
            2'h0:    filt_cyc = bemf_cond_pkg::FILT_CYC_0;
            2'h1:    filt_cyc = bemf_cond_pkg::FILT_CYC_1;
            2'h2:    filt_cyc = bemf_cond_pkg::FILT_CYC_2;
            default: filt_cyc = bemf_cond_pkg::FILT_CYC_3;
        endcase
    end

    always_comb
    begin
        case (trim_q.blanking_time_sel)
            3'h0:    blank_cyc = bemf_cond_pkg::BLANK_CYC_0;
            3'h1:    blank_cyc = bemf_cond_pkg::BLANK_CYC_1;
            3'h2:    blank_cyc = bemf_cond_pkg::BLANK_CYC_2;
            3'h3:    blank_cyc = bemf_cond_pkg::BLANK_CYC_3;
            default: blank_cyc = bemf_cond_pkg::BLANK_CYC_HI;
        endcase
    end

    // ------------------------------------------------------------
    // blanking window, shared by all phases
    // ------------------------------------------------------------
    logic [bemf_cond_pkg::CNT_W-1:0] blank_cnt_q;
    wire blanking = blank_cnt_q != '0;

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            blank_cnt_q <= '0;
        else if (i_blank_start)
            blank_cnt_q <= blank_cyc;
        else if (blanking)
            blank_cnt_q <= blank_cnt_q - 1'b1;
    end

    // ------------------------------------------------------------
    // per phase conditioning
    // ------------------------------------------------------------
    for (genvar p = 0; p < N_PH; p++)
    begin : g_ph
        logic                            s1_q;
        logic                            s2_q;
        logic                            demag_q;
        logic                            filt_q;
        logic [bemf_cond_pkg::CNT_W-1:0] dcnt_q;
        logic [bemf_cond_pkg::CNT_W-1:0] fcnt_q;

        // demag stage passes a new level only after it stays stable
        wire demag_in  = s2_q;
        wire demag_out = ctrl_q.demag_filter_disable ? demag_in : demag_q;
        wire filt_out  = ctrl_q.output_filter_bypass ? demag_out : filt_q;

        always_ff @(posedge i_mclk)
        begin
            if (i_rst)
            begin
                s1_q    <= 1'b1;
                s2_q    <= 1'b1;
                demag_q <= 1'b1;
                filt_q  <= 1'b1;
                dcnt_q  <= '0;
                fcnt_q  <= '0;
            end
            else
            begin
                s1_q <= i_comp_raw[p];
                s2_q <= s1_q;
                if (demag_in == demag_q)
                    dcnt_q <= '0;
                else if (dcnt_q >= bemf_cond_pkg::DEMAG_CYC - 1'b1)
                begin
                    demag_q <= demag_in;
                    dcnt_q  <= '0;
                end
                else
                    dcnt_q <= dcnt_q + 1'b1;
                // length is read at every compare, so a new code acts at the next edge
                if (demag_out == filt_q)
                    fcnt_q <= '0;
                else if (fcnt_q >= filt_cyc - 1'b1)
                begin
                    filt_q <= demag_out;
                    fcnt_q <= '0;
                end
                else
                    fcnt_q <= fcnt_q + 1'b1;
            end
        end

        always_ff @(posedge i_mclk)
        begin
            if (i_rst)
                sts_q[p] <= 1'b1;
            else if (!ctrl_q.comp_on[p])
                sts_q[p] <= 1'b1;
            else if (!blanking)
                sts_q[p] <= filt_out;
        end
    end

    // ------------------------------------------------------------
    // capture source mux
    // ------------------------------------------------------------
    logic cap_d;

    always_comb
    begin
        case (trim_q.capture_source_sel)
            bemf_cond_pkg::SRC_SOFT: cap_d = ctrl_q.capture_soft_trigger;
            bemf_cond_pkg::SRC_PH_U: cap_d = sts_q[0];
            bemf_cond_pkg::SRC_PH_V: cap_d = sts_q[1];
            bemf_cond_pkg::SRC_PH_W: cap_d = sts_q[2];
            default:                 cap_d = 1'b0;
        endcase
    end

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            cap_q <= 1'b0;
        else
            cap_q <= cap_d;
    end

    logic [N_PH-1:0] on_q;

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
            on_q <= '0;
        else
            on_q <= ctrl_q.comp_on;
    end

    assign o_rdata                 = rdata_q;
    assign o_phase_crossing_status = sts_q;
    assign o_comp_on               = on_q;
    assign o_capture_in            = cap_q;

endmodule : bemf_cond

// [shared/bemf_cond_pkg.sv]
/*
 * constants and carrier types for the back-emf comparator output
 * conditioning block. assumes a 100 MHz system clock.
 */
// Notes on behaviour
// - the output filter time follows a two-bit code: 1, 2, 4 or 8 us.
// - blanking time follows a three-bit code: 6, 8, 12, 16 us, or 3 us when the top bit is set.
// - the capture source code picks soft trigger, phase u, phase v or phase w for the timer.
// - reset returns the trim register to all zeros.
// - each phase status is one above threshold, zero below, and one while its comparator is off.
// - the bypass bit, when one, skips the output filter.
// - the demag filter disable bit, when one, bypasses the demag filter.
// - the soft trigger bit is written by software and drives the capture input on source 00.
package bemf_cond_pkg;

    // ------------------------------------------------------------
    // clock and times
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ          = 100;
    localparam int unsigned FILT_US_0        = 1;
    localparam int unsigned FILT_US_1        = 2;
    localparam int unsigned FILT_US_2        = 4;
    localparam int unsigned FILT_US_3        = 8;
    localparam int unsigned BLANK_US_0       = 6;
    localparam int unsigned BLANK_US_1       = 8;
    localparam int unsigned BLANK_US_2       = 12;
    localparam int unsigned BLANK_US_3       = 16;
    localparam int unsigned BLANK_US_HI      = 3;
    localparam int unsigned DEMAG_US         = 1;
    localparam int unsigned CNT_W            = 11;
    localparam logic [CNT_W-1:0] FILT_CYC_0  = CNT_W'(FILT_US_0 * CLK_MHZ);
    localparam logic [CNT_W-1:0] FILT_CYC_1  = CNT_W'(FILT_US_1 * CLK_MHZ);
    localparam logic [CNT_W-1:0] FILT_CYC_2  = CNT_W'(FILT_US_2 * CLK_MHZ);
    localparam logic [CNT_W-1:0] FILT_CYC_3  = CNT_W'(FILT_US_3 * CLK_MHZ);
    localparam logic [CNT_W-1:0] BLANK_CYC_0 = CNT_W'(BLANK_US_0 * CLK_MHZ);
    localparam logic [CNT_W-1:0] BLANK_CYC_1 = CNT_W'(BLANK_US_1 * CLK_MHZ);
    localparam logic [CNT_W-1:0] BLANK_CYC_2 = CNT_W'(BLANK_US_2 * CLK_MHZ);
    localparam logic [CNT_W-1:0] BLANK_CYC_3 = CNT_W'(BLANK_US_3 * CLK_MHZ);
    localparam logic [CNT_W-1:0] BLANK_CYC_HI = CNT_W'(BLANK_US_HI * CLK_MHZ);
    localparam logic [CNT_W-1:0] DEMAG_CYC   = CNT_W'(DEMAG_US * CLK_MHZ);

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0]  TRIM_OFS         = 8'h20;
    localparam logic [7:0]  CTRL_OFS         = 8'h24;
    localparam logic [31:0] TRIM_RST         = 32'h0000_0000;
    localparam logic [31:0] CTRL_RST         = 32'h0000_0000;
    localparam int unsigned TRIM_BLANK_LSB   = 0;
    localparam int unsigned TRIM_SRC_LSB     = 4;
    localparam int unsigned TRIM_RES_LSB     = 6;
    localparam int unsigned TRIM_FILT_LSB    = 8;
    localparam int unsigned TRIM_RES3        = 3;
    localparam int unsigned CTRL_DEMAG_BIT   = 3;
    localparam int unsigned CTRL_BYP_BIT     = 4;
    localparam int unsigned CTRL_SWTRIG_BIT  = 5;
    localparam int unsigned CTRL_ON_LSB      = 8;
    localparam int unsigned CTRL_STS_LSB     = 16;

    typedef enum logic [1:0] {
        SRC_SOFT  = 2'b00,
        SRC_PH_U  = 2'b01,
        SRC_PH_V  = 2'b10,
        SRC_PH_W  = 2'b11
    } capture_src_e;

    typedef struct packed {
        logic [1:0]   output_filter_time_sel;
        logic [1:0]   res_7_6;
        capture_src_e capture_source_sel;
        logic         res_3;
        logic [2:0]   blanking_time_sel;
    } trim_s;

    typedef struct packed {
        logic [2:0] comp_on;
        logic       capture_soft_trigger;
        logic       output_filter_bypass;
        logic       demag_filter_disable;
    } ctrl_s;

endpackage : bemf_cond_pkg

// [testbench/bemf_phase_model.sv]
/*
 * comparator and capture timer model for the bemf_cond bench.
 * assumes levels come from the bench and the timer sits on i_mclk.
 */
`timescale 1ns/10ps
module bemf_phase_model #(
    parameter bit CAPTURE_PIN_ROUTE = 1'b1
) (
    input  wire logic       i_mclk,
    input  wire logic [2:0] i_level,
    input  wire logic       i_capture_in,
    output logic      [2:0] o_raw,
    output int              o_edges
);
    logic cap_q = 1'b0;
    initial o_edges = 0;
    // comparators switch off the clock edge
    assign #3 o_raw = i_level;
    always @(posedge i_mclk)
    begin
        if (CAPTURE_PIN_ROUTE && i_capture_in && !cap_q)
            o_edges <= o_edges + 1;
        cap_q <= i_capture_in;
    end
endmodule : bemf_phase_model

// [testbench/bemf_cond_checker.sv]
/*
 * port assertions for bemf_cond, bound after the module.
 * assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/10ps
module bemf_cond_checker #(
    parameter int unsigned N_PH = 3
) (
    input wire logic            i_mclk,
    input wire logic            i_rst,
    input wire logic [7:0]      i_addr,
    input wire logic [31:0]     i_wdata,
    input wire logic            i_wr,
    input wire logic            i_rd,
    input wire logic [31:0]     o_rdata,
    input wire logic [N_PH-1:0] i_comp_raw,
    input wire logic            i_blank_start,
    input wire logic [N_PH-1:0] o_phase_crossing_status,
    input wire logic [N_PH-1:0] o_comp_on,
    input wire logic            o_capture_in
);
    logic [9:0]  trim_q;
    logic        byp_q;
    logic        raw_q;
    logic [11:0] stab_q;
    logic [11:0] blank_q;
    logic [11:0] blank_cyc;
    logic [11:0] filt_cyc;
    logic        sel_sts;
    logic        wr_ctrl;
    assign wr_ctrl   = i_wr && (i_addr == 8'h24);
    assign filt_cyc  = 12'h064 << trim_q[9:8];
    assign blank_cyc = trim_q[2] ? 12'h12c : trim_q[1] ? (trim_q[0] ? 12'h640 : 12'h4b0)
                                           : (trim_q[0] ? 12'h320 : 12'h258);
    assign sel_sts   = o_phase_crossing_status[trim_q[5:4] - 2'h1];
    // shadow of the trim and bypass settings, raw stability and blanking counts
    always_ff @(posedge i_mclk)
    begin
        raw_q <= i_comp_raw[0];
        if (i_rst)
        begin
            trim_q  <= 10'h000;
            byp_q   <= 1'b0;
            stab_q  <= 12'h000;
            blank_q <= 12'h000;
        end
        else
        begin
            if (i_wr && i_addr == 8'h20)
                trim_q <= i_wdata[9:0];
            if (wr_ctrl)
                byp_q <= i_wdata[4];
            stab_q <= (i_comp_raw[0] != raw_q) ? 12'h000 : stab_q + {11'h000, stab_q != 12'hfff};
            if (i_blank_start)
                blank_q <= blank_cyc;
            else if (blank_q != 12'h000)
                blank_q <= blank_q - 12'h001;
        end
    end
    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_rst);
    sequence s_soft_wr;
        wr_ctrl && (trim_q[5:4] == 2'b00) ##1 (!i_wr) [*2];
    endsequence
    chk_reset_vals:
        assert property ($fell(i_rst) |-> &o_phase_crossing_status && !o_capture_in
            && o_comp_on == '0) else $error("bad state after reset");
    chk_rdata_idle:
        assert property (!i_rd |=> o_rdata == 32'h0) else $error("read data outside read");
    chk_trim_read:
        assert property (i_rd && i_addr == 8'h20 |=> o_rdata == {22'h0, trim_q})
        else $error("trim read data wrong");
    chk_comp_off:
        assert property ((~o_comp_on & ~$past(o_comp_on) & ~o_phase_crossing_status) == '0)
        else $error("off comparator not one");
    chk_capture_mux:
        assert property (trim_q[5:4] != 2'b00 && $stable(trim_q[5:4])
            |-> o_capture_in == $past(sel_sts)) else $error("capture source wrong");
    chk_soft_trig:
        assert property (s_soft_wr |-> ##1 o_capture_in == $past(i_wdata[5], 3))
        else $error("soft trigger not on capture");
    chk_filter_min:
        assert property ($changed(o_phase_crossing_status[0]) && o_comp_on[0]
            && $past(o_comp_on[0]) && $past(o_comp_on[0], 2) && !byp_q
            |-> {1'b0, $past(stab_q, 4)} + 13'h0004 >= {1'b0, filt_cyc})
        else $error("output filter too short");
    chk_blank_hold:
        assert property (blank_q > 12'h001 && blank_q < blank_cyc && $stable(o_comp_on)
            && o_comp_on == $past(o_comp_on, 2) |-> $stable(o_phase_crossing_status))
        else $error("status moved in blanking");
endmodule : bemf_cond_checker
bind bemf_cond bemf_cond_checker #(.N_PH(N_PH)) u_bemf_cond_checker (.i_mclk(i_mclk),
    .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
    .o_rdata(o_rdata), .i_comp_raw(i_comp_raw), .i_blank_start(i_blank_start),
    .o_phase_crossing_status(o_phase_crossing_status), .o_comp_on(o_comp_on),
    .o_capture_in(o_capture_in));

// [testbench/bemf_cond_tb.sv]
/*
 * self-checking bench for bemf_cond with the comparator model.
 * assumes the checker file binds itself to the design.
 */
`timescale 1ns/10ps
module bemf_cond_tb;
    logic        mclk  = 1'b0;
    logic        rst   = 1'b1;
    logic [7:0]  addr  = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic        blank = 1'b0;
    logic [2:0]  lvl   = 3'h0;
    logic [31:0] rdata;
    logic [31:0] got;
    logic [2:0]  raw;
    logic [2:0]  sts;
    logic [2:0]  on;
    logic        cap;
    int          edges;
    int          n_fail = 0;
    int          checks = 0;
    always #5 mclk = ~mclk;
    bemf_cond u_bemf_cond (.i_mclk(mclk), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_comp_raw(raw), .i_blank_start(blank),
        .o_phase_crossing_status(sts), .o_comp_on(on), .o_capture_in(cap));
    bemf_phase_model u_bemf_phase_model (.i_mclk(mclk), .i_level(lvl), .i_capture_in(cap),
        .o_raw(raw), .o_edges(edges));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h exp %h", $time, m, g, e);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : cyc
    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr    <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a);
        @(posedge mclk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge mclk);
        rd   <= 1'b0;
        #1;
        got = rdata;
    endtask : reg_rd
    task automatic report_and_stop;
        $display("checks %0d failures %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop
    task automatic t_regs;
        int e0;
        chk({25'h0, sts, on, cap}, 32'h70, "outputs after reset");
        reg_rd(8'h20);
        chk(got, 32'h0, "trim reset");
        reg_wr(8'h20, 32'hffff_ffff);
        reg_rd(8'h20);
        chk(got, 32'h3ff, "trim upper bits");
        reg_wr(8'h28, 32'hffff_ffff);
        reg_rd(8'h28);
        chk(got, 32'h0, "unmapped read");
        reg_wr(8'h20, 32'h0);
        // phase w was selected while off, so one capture edge came before
        e0 = edges;
        reg_wr(8'h24, 32'h20);
        cyc(3);
        chk(32'(cap), 32'h1, "soft trigger set");
        chk(32'(edges - e0), 32'h1, "timer edge count");
        reg_wr(8'h24, 32'h0);
        cyc(3);
        chk(32'(cap), 32'h0, "soft trigger clear");
        $display("register test done");
    endtask : t_regs
    task automatic t_filter;
        reg_wr(8'h24, 32'h708);
        for (int s = 0; s < 4; s++)
        begin
            reg_wr(8'h20, 32'(s) << 8);
            lvl <= 3'h0;
            cyc(1000);
            lvl <= 3'h7;
            cyc((100 << s) - 10);
            chk(32'(sts[0]), 32'h0, "filter early");
            cyc(30);
            chk(32'(sts[0]), 32'h1, "filter late");
        end
        reg_wr(8'h24, 32'h710);
        lvl <= 3'h0;
        cyc(300);
        lvl <= 3'h7;
        cyc(90);
        chk(32'(sts[0]), 32'h0, "demag early");
        cyc(30);
        chk(32'(sts[0]), 32'h1, "demag late");
        reg_wr(8'h24, 32'h718);
        lvl <= 3'h0;
        cyc(8);
        chk(32'(sts[0]), 32'h0, "bypass slow");
        $display("filter test done");
    endtask : t_filter
    task automatic t_blank;
        logic [2:0] code [5] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h7};
        int         len  [5] = '{600, 800, 1200, 1600, 300};
        for (int i = 0; i < 5; i++)
        begin
            reg_wr(8'h20, {29'h0, code[i]});
            lvl <= 3'h0;
            cyc(20);
            @(posedge mclk);
            blank <= 1'b1;
            @(posedge mclk);
            blank <= 1'b0;
            lvl   <= 3'h7;
            cyc(len[i] - 20);
            chk(32'(sts[0]), 32'h0, "blanking short");
            cyc(40);
            chk(32'(sts[0]), 32'h1, "blanking long");
        end
        $display("blanking test done");
    endtask : t_blank
    task automatic t_mux;
        for (int s = 1; s < 4; s++)
        begin
            reg_wr(8'h20, 32'(s) << 4);
            lvl <= 3'(1 << (s - 1));
            cyc(10);
            chk(32'(cap), 32'h1, "capture high");
            lvl <= ~3'(1 << (s - 1));
            cyc(10);
            chk(32'(cap), 32'h0, "capture low");
        end
        reg_wr(8'h24, 32'h618);
        lvl <= 3'h0;
        cyc(10);
        chk({26'h0, sts, on}, 32'h0e, "phase u off");
        reg_rd(8'h24);
        chk(got, 32'h0001_0618, "ctrl and status read");
        $display("mux test done");
    endtask : t_mux
    initial
    begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        cyc(1);
        t_regs();
        t_filter();
        t_blank();
        t_mux();
        report_and_stop();
    end
    initial
    begin
        #600000;
        n_fail++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        report_and_stop();
    end
endmodule : bemf_cond_tb
